// [include/lccs_pkg.sv]
// Purpose: Shared constants for the logic cluster control block
// Assumes: One fabric clock; row clock lines arrive from outside its domain
// Notes: Cluster clocks are modelled as one-cycle update strobes on ref_clk_in
package lccs_pkg;
    localparam int NUM_CELLS = 10;
    localparam int REGS_PER_CELL = 2;
    localparam int NUM_REGS = NUM_CELLS * REGS_PER_CELL;
    localparam int NUM_CLOCKS = 3;
    localparam int NUM_SOURCES = 2;
    localparam int NUM_ROW = 6;
    localparam int NUM_ACLR = 2;
    localparam int MAX_CTRL = 10;
    localparam int CTRL_W = 4;
    localparam int SYNC_STAGES = 3;
    localparam int SRC_SEL_W = 3;
    localparam logic [2:0] SRC_LOCAL = 3'h6;
    localparam logic [2:0] SRC_NONE = 3'h7;
    localparam int CLK_SEL_W = 2;
    localparam int MEM_WORDS = 16;
    localparam int MEM_AW = 4;
    localparam int MEM_BITS_PER_CELL = 2;
    localparam int MEM_WIDTH = NUM_CELLS * MEM_BITS_PER_CELL;
    localparam int MEM_TOTAL_BITS = MEM_WORDS * MEM_WIDTH;
    localparam logic Q_RESET = 1'b0;
    localparam logic [NUM_REGS-1:0] REGS_RESET = 20'h00000;
    localparam logic [MEM_WIDTH-1:0] MEM_RESET = 20'h00000;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
endpackage

// [logic/lccs_cluster_ctrl.sv]
// Purpose: Control signal generation and cell registers of one logic cluster
// Assumes: Clock, clear and load sources are configured by static inputs
// Notes: Edges of the selected sources become one-cycle update strobes
module lccs_cluster_ctrl (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Dedicated row clock lines and local interconnect sources
    input wire logic [lccs_pkg::NUM_ROW-1:0] row_clock_in,
    input wire logic [lccs_pkg::NUM_SOURCES-1:0] local_clock_in,
    input wire logic [lccs_pkg::NUM_SOURCES*lccs_pkg::SRC_SEL_W-1:0] src_sel_in,
    // Cluster clock configuration
    input wire logic [lccs_pkg::NUM_CLOCKS-1:0] clk_use_in,
    input wire logic [lccs_pkg::NUM_CLOCKS-1:0] clk_src_in,
    input wire logic [lccs_pkg::NUM_CLOCKS-1:0] clk_fall_in,
    input wire logic [lccs_pkg::NUM_CLOCKS-1:0] cluster_clock_gate_in,
    // Cluster clears and loads
    input wire logic [lccs_pkg::NUM_ACLR-1:0] cluster_async_clear_in,
    input wire logic sync_clear_in,
    input wire logic sync_load_in,
    // Per-register configuration
    input wire logic [lccs_pkg::NUM_REGS*lccs_pkg::CLK_SEL_W-1:0] reg_clk_sel_in,
    input wire logic [lccs_pkg::NUM_REGS-1:0] reg_aclr_use_in,
    input wire logic [lccs_pkg::NUM_REGS-1:0] reg_aclr_sel_in,
    input wire logic [lccs_pkg::NUM_REGS-1:0] reg_sclr_use_in,
    input wire logic [lccs_pkg::NUM_REGS-1:0] reg_sload_use_in,
    input wire logic [lccs_pkg::NUM_REGS-1:0] reg_chain_sel_in,
    // Cell data
    input wire logic [lccs_pkg::NUM_REGS-1:0] cell_data_in,
    input wire logic [lccs_pkg::NUM_REGS-1:0] cell_load_data_in,
    input wire logic [lccs_pkg::REGS_PER_CELL-1:0] chain_in,
    // Memory mode
    input wire logic mem_mode_in,
    input wire logic mem_wr_en_in,
    input wire logic [lccs_pkg::MEM_AW-1:0] mem_wr_addr_in,
    input wire logic [lccs_pkg::MEM_WIDTH-1:0] mem_wr_data_in,
    input wire logic [lccs_pkg::MEM_AW-1:0] mem_rd_addr_in,
    // Outputs
    output logic [lccs_pkg::NUM_REGS-1:0] cell_q_out,
    output logic [lccs_pkg::NUM_CLOCKS-1:0] cluster_clock_out,
    output logic [lccs_pkg::CTRL_W-1:0] ctrl_count_out,
    output logic [lccs_pkg::MEM_WIDTH-1:0] mem_rd_data_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [lccs_pkg::CTRL_W-1:0] ones3(input logic [2:0] v);
        ones3 = {3'h0, v[0]} + {3'h0, v[1]} + {3'h0, v[2]};
    endfunction

    function automatic logic sel_bit(input logic [lccs_pkg::NUM_ROW-1:0] row,
                                     input logic loc, input logic [2:0] sel);
        if (sel == lccs_pkg::SRC_LOCAL) begin
            sel_bit = loc;
        end else if (sel < 3'h6) begin
            sel_bit = row[sel];
        end else begin
            sel_bit = 1'b0;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Row line synchronisers: a change counts once stages two and three agree

    logic [lccs_pkg::NUM_ROW-1:0] row_s1_reg;
    logic [lccs_pkg::NUM_ROW-1:0] row_s2_reg;
    logic [lccs_pkg::NUM_ROW-1:0] row_s3_reg;
    logic [lccs_pkg::NUM_ROW-1:0] row_lvl_reg;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            row_s1_reg <= 6'h00;
            row_s2_reg <= 6'h00;
            row_s3_reg <= 6'h00;
            row_lvl_reg <= 6'h00;
        end else begin
            row_s1_reg <= row_clock_in;
            row_s2_reg <= row_s1_reg;
            row_s3_reg <= row_s2_reg;
            for (int i = 0; i < lccs_pkg::NUM_ROW; i++) begin
                if (row_s2_reg[i] == row_s3_reg[i]) begin
                    row_lvl_reg[i] <= row_s3_reg[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two clock sources and their edges

    logic [lccs_pkg::NUM_SOURCES-1:0] src_lvl;
    logic [lccs_pkg::NUM_SOURCES-1:0] src_prev_reg;
    logic [lccs_pkg::NUM_SOURCES-1:0] src_rise;
    logic [lccs_pkg::NUM_SOURCES-1:0] src_fall;

    always_comb begin
        for (int s = 0; s < lccs_pkg::NUM_SOURCES; s++) begin
            src_lvl[s] = sel_bit(row_lvl_reg, local_clock_in[s], src_sel_in[s*3 +: 3]);
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            src_prev_reg <= 2'h0;
        end else begin
            src_prev_reg <= src_lvl;
        end
    end

    assign src_rise = src_lvl & ~src_prev_reg;
    assign src_fall = ~src_lvl & src_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Cluster clocks: source edge gated by the same-index gate

    logic [lccs_pkg::NUM_CLOCKS-1:0] clk_tick;

    always_comb begin
        for (int c = 0; c < lccs_pkg::NUM_CLOCKS; c++) begin
            // A source used on both edges needs two clocks, one per edge
            clk_tick[c] = clk_use_in[c] & cluster_clock_gate_in[c]
                & (clk_fall_in[c] ? src_fall[clk_src_in[c]]
                                  : src_rise[clk_src_in[c]]);
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cluster_clock_out <= 3'h0;
            ctrl_count_out <= lccs_pkg::CTRL_RESET;
        end else begin
            cluster_clock_out <= clk_tick;
            // Each used clock brings its gate along, so it counts twice
            ctrl_count_out <= ones3(clk_use_in) + ones3(clk_use_in)
                + ones3({1'b0, |(reg_aclr_use_in & ~reg_aclr_sel_in),
                         |(reg_aclr_use_in & reg_aclr_sel_in)})
                + ones3({1'b0, |reg_sclr_use_in, |reg_sload_use_in});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cell registers, two per cell, all on the shared controls

    logic [lccs_pkg::NUM_REGS-1:0] reg_tick;
    logic [lccs_pkg::NUM_REGS-1:0] reg_aclr_hit;
    logic [lccs_pkg::NUM_REGS-1:0] reg_d;

    always_comb begin
        for (int k = 0; k < lccs_pkg::NUM_REGS; k++) begin
            reg_tick[k] = clk_tick[reg_clk_sel_in[k*2 +: 2] % 3];
            reg_aclr_hit[k] = reg_aclr_use_in[k]
                & cluster_async_clear_in[reg_aclr_sel_in[k]];
            if (k < lccs_pkg::REGS_PER_CELL) begin
                reg_d[k] = reg_chain_sel_in[k] ? chain_in[k] : cell_data_in[k];
            end else begin
                reg_d[k] = reg_chain_sel_in[k] ? cell_q_out[k-2] : cell_data_in[k];
            end
        end
    end

    // Asynchronous clears act regardless of clock strobes; synchronous clear and load wait for a strobe; mode never masks them
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cell_q_out <= lccs_pkg::REGS_RESET;
        end else begin
            for (int k = 0; k < lccs_pkg::NUM_REGS; k++) begin
                if (reg_aclr_hit[k]) begin
                    cell_q_out[k] <= lccs_pkg::Q_RESET;
                end else if (reg_tick[k]) begin
                    if (reg_sclr_use_in[k] && sync_clear_in) begin
                        cell_q_out[k] <= lccs_pkg::Q_RESET;
                    end else if (reg_sload_use_in[k] && sync_load_in) begin
                        cell_q_out[k] <= cell_load_data_in[k];
                    end else begin
                        cell_q_out[k] <= reg_d[k];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory mode: writes on cluster clock 0, registered read port

    logic [lccs_pkg::MEM_WIDTH-1:0] mem_array [lccs_pkg::MEM_WORDS];

    always_ff @(posedge ref_clk_in) begin
        if (mem_mode_in && mem_wr_en_in && clk_tick[0]) begin
            mem_array[mem_wr_addr_in] <= mem_wr_data_in;
        end
    end

    // Array has no reset, so read data is forced clean while mode is off
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_rd_data_out <= lccs_pkg::MEM_RESET;
        end else if (mem_mode_in) begin
            mem_rd_data_out <= mem_array[mem_rd_addr_in];
        end else begin
            mem_rd_data_out <= lccs_pkg::MEM_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    a_gate_stops_clock: assert property (
        cluster_clock_out[1] |-> $past(cluster_clock_gate_in[1]))
        else $error("cluster clock 1 ran while its gate was low");
    a_clock_has_edge: assert property (
        cluster_clock_out[0] |-> $past(clk_fall_in[0] ? src_fall[clk_src_in[0]]
                                                      : src_rise[clk_src_in[0]]))
        else $error("cluster clock 0 fired without a source edge");
    a_both_edges_two: assert property (
        (clk_use_in[0] && clk_use_in[1] && cluster_clock_gate_in[1:0] == 2'h3
         && clk_src_in[0] == clk_src_in[1] && clk_fall_in[0] != clk_fall_in[1])
        |-> !(clk_tick[0] && clk_tick[1]))
        else $error("rise and fall clocks of one source fired together");
    a_hold_stopped: assert property (
        !reg_tick[0] && !reg_aclr_hit[0] |=> $stable(cell_q_out[0]))
        else $error("register held by a stopped clock changed");
    a_aclr_zero: assert property (
        reg_aclr_hit[3] |=> cell_q_out[3] == 1'b0)
        else $error("asynchronous clear did not zero the register");
    a_chain_path: assert property (
        reg_tick[2] && reg_chain_sel_in[2] && !reg_aclr_hit[2]
        && !(reg_sclr_use_in[2] && sync_clear_in) && !(reg_sload_use_in[2] && sync_load_in)
        |=> cell_q_out[2] == $past(cell_q_out[0]))
        else $error("register chain did not pass the neighbour value");
    a_ctrl_limit: assert property (
        ctrl_count_out <= 4'hA)
        else $error("more than ten control signals in use");
    a_row_filter: assert property (
        row_lvl_reg[0] != $past(row_lvl_reg[0]) |-> $past(row_s2_reg[0] == row_s3_reg[0]))
        else $error("row line level changed without two agreeing samples");
    a_mem_readback: assert property (
        mem_mode_in && mem_wr_en_in && clk_tick[0] ##1 mem_mode_in
        && mem_rd_addr_in == $past(mem_wr_addr_in) && !(mem_wr_en_in && clk_tick[0])
        |=> mem_rd_data_out == $past(mem_wr_data_in, 2))
        else $error("memory read did not return the written word");

    c_clock_tick: cover property (cluster_clock_out[0]);
    c_chain_shift: cover property (reg_tick[2] && reg_chain_sel_in[2]);
    c_aclr_hit: cover property (|reg_aclr_hit);
    c_mem_write: cover property (mem_mode_in && mem_wr_en_in && clk_tick[0]);

endmodule

// [verif/lccs_cell_model.sv]
// Purpose: Stand-in for the adaptive logic cells that feed the cluster registers
// Assumes: Cells present new data just after every rising clock edge
// Notes: Data changes each cycle so a stale capture never matches by luck
module lccs_cell_model (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Cell outputs toward the cluster registers
    output logic [19:0] data_out,
    output logic [19:0] load_out,
    output logic [1:0] chain_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] data_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // Twisted ring: 40 distinct states, so no value repeats within a scenario
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_reg <= 20'h5A3C1;
        end else begin
            data_reg <= {data_reg[18:0], ~data_reg[19]};
        end
    end
    assign data_out = data_reg;
    assign load_out = ~{data_reg[9:0], data_reg[19:10]};
    assign chain_out = ~data_reg[19:18];
endmodule

// [verif/test_logic_cluster_control_signals.sv]
// Purpose: Self-checking bench for the cluster control block
// Assumes: All regs on cluster clock 0 unless a scenario moves them
// Notes: Local sources give exact strobe timing; row lines add sync delay
module test_logic_cluster_control_signals;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [5:0] row_clock_in = 6'h00;
    logic [1:0] local_clock_in = 2'h0;
    logic [5:0] src_sel_in = {lccs_pkg::SRC_LOCAL, lccs_pkg::SRC_LOCAL};
    logic [2:0] clk_use_in = 3'h7;
    logic [2:0] clk_src_in = 3'h4;
    logic [2:0] clk_fall_in = 3'h2;
    logic [2:0] cluster_clock_gate_in = 3'h7;
    logic [1:0] cluster_async_clear_in = 2'h0;
    logic sync_clear_in = 1'b0;
    logic sync_load_in = 1'b0;
    logic mem_mode_in = 1'b0;
    logic mem_wr_en_in = 1'b0;
    logic [39:0] reg_clk_sel_in = 40'h0000000000;
    logic [19:0] reg_aclr_use_in = 20'h00000;
    logic [19:0] reg_aclr_sel_in = 20'h00000;
    logic [19:0] reg_sclr_use_in = 20'h00000;
    logic [19:0] reg_sload_use_in = 20'h00000;
    logic [19:0] reg_chain_sel_in = 20'h00000;
    logic [19:0] mem_wr_data_in = 20'h00000;
    logic [3:0] mem_wr_addr_in = 4'h0;
    logic [3:0] mem_rd_addr_in = 4'h0;
    wire logic [19:0] cell_data, load_data, cell_q_out, mem_rd_data_out;
    wire logic [1:0] chain_data;
    wire logic [2:0] cluster_clock_out;
    wire logic [3:0] ctrl_count_out;
    int miscompares = 0;
    int n_tests = 0;
    logic [19:0] exp_q = 20'h00000;
    always #5 ref_clk_in = ~ref_clk_in;
    ////////////////////////////////////////////////////////////////////////////////
    lccs_cell_model i_cells (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .data_out(cell_data),
        .load_out(load_data), .chain_out(chain_data));
    lccs_cluster_ctrl i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .row_clock_in(row_clock_in), .local_clock_in(local_clock_in), .src_sel_in(src_sel_in),
        .clk_use_in(clk_use_in), .clk_src_in(clk_src_in), .clk_fall_in(clk_fall_in),
        .cluster_clock_gate_in(cluster_clock_gate_in),
        .cluster_async_clear_in(cluster_async_clear_in), .sync_clear_in(sync_clear_in),
        .sync_load_in(sync_load_in), .reg_clk_sel_in(reg_clk_sel_in),
        .reg_aclr_use_in(reg_aclr_use_in), .reg_aclr_sel_in(reg_aclr_sel_in),
        .reg_sclr_use_in(reg_sclr_use_in), .reg_sload_use_in(reg_sload_use_in),
        .reg_chain_sel_in(reg_chain_sel_in), .cell_data_in(cell_data),
        .cell_load_data_in(load_data), .chain_in(chain_data), .mem_mode_in(mem_mode_in),
        .mem_wr_en_in(mem_wr_en_in), .mem_wr_addr_in(mem_wr_addr_in),
        .mem_wr_data_in(mem_wr_data_in), .mem_rd_addr_in(mem_rd_addr_in),
        .cell_q_out(cell_q_out), .cluster_clock_out(cluster_clock_out),
        .ctrl_count_out(ctrl_count_out), .mem_rd_data_out(mem_rd_data_out));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tick();
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask
    // Kind of capture expected on clock 0: 0 hold, 1 data, 2 load, 3 zero, 4 chain shift
    task automatic src_edge(input int s, input logic v, input int kind);
        if (kind == 1) exp_q = cell_data;
        if (kind == 2) exp_q = load_data;
        if (kind == 3) exp_q = 20'h00000;
        if (kind == 4) exp_q = {exp_q[17:0], chain_data};
        local_clock_in[s] = v;
        tick();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_count();
        check(20'(ctrl_count_out), 20'h00006);
        clk_use_in = 3'h1;
        tick();
        check(20'(ctrl_count_out), 20'h00002);
        clk_use_in = 3'h7;
    endtask
    task automatic t_edges();
        src_edge(0, 1'b1, 1);
        check(cell_q_out, exp_q);
        check(20'(cluster_clock_out), 20'h00001);
        src_edge(0, 1'b0, 0);
        check(20'(cluster_clock_out), 20'h00002);
        check(cell_q_out, exp_q);
        src_edge(1, 1'b1, 0);
        check(20'(cluster_clock_out), 20'h00004);
        src_edge(1, 1'b0, 0);
        check(20'(cluster_clock_out), 20'h00000);
    endtask
    task automatic t_gate();
        cluster_clock_gate_in = 3'h6;
        src_edge(0, 1'b1, 0);
        check(20'(cluster_clock_out), 20'h00000);
        check(cell_q_out, exp_q);
        src_edge(0, 1'b0, 0);
        check(20'(cluster_clock_out), 20'h00002);
        cluster_clock_gate_in = 3'h7;
    endtask
    task automatic t_clears();
        reg_aclr_use_in = 20'hFFFFF;
        cluster_async_clear_in = 2'h2;
        tick();
        check(cell_q_out, exp_q);
        check(20'(ctrl_count_out), 20'h00007);
        cluster_async_clear_in = 2'h1;
        tick();
        check(cell_q_out, 20'h00000);
        src_edge(0, 1'b1, 3);
        check(cell_q_out, exp_q);
        cluster_async_clear_in = 2'h0;
        src_edge(0, 1'b0, 0);
        reg_sload_use_in = 20'hFFFFF;
        sync_load_in = 1'b1;
        src_edge(0, 1'b1, 2);
        check(cell_q_out, exp_q);
        src_edge(0, 1'b0, 0);
        reg_sclr_use_in = 20'hFFFFF;
        sync_clear_in = 1'b1;
        src_edge(0, 1'b1, 3);
        check(cell_q_out, exp_q);
        check(20'(ctrl_count_out), 20'h00009);
        {sync_clear_in, sync_load_in} = 2'h0;
        {reg_aclr_use_in, reg_sload_use_in, reg_sclr_use_in} = 60'h0;
        src_edge(0, 1'b0, 0);
    endtask
    task automatic t_chain();
        reg_chain_sel_in = 20'hFFFFF;
        repeat (2) begin
            src_edge(0, 1'b1, 4);
            check(cell_q_out, exp_q);
            src_edge(0, 1'b0, 0);
        end
        reg_chain_sel_in = 20'h00000;
    endtask
    task automatic t_row();
        int n;
        src_sel_in = {3'h3, lccs_pkg::SRC_LOCAL};
        reg_clk_sel_in = 40'hAAAAAAAAAA;
        tick();
        row_clock_in[3] = 1'b1;
        for (n = 1; n <= 8; n++) begin
            exp_q = cell_data;
            tick();
            if (cluster_clock_out[2] === 1'b1) break;
        end
        if (n > 8) begin
            miscompares++;
            stop_test();
        end
        // Three sync stages plus the agreement flop, then the strobe edge
        check(20'(n), 20'h00005);
        check(cell_q_out, exp_q);
        row_clock_in[3] = 1'b0;
        repeat (5) tick();
        src_sel_in = {lccs_pkg::SRC_LOCAL, lccs_pkg::SRC_LOCAL};
        reg_clk_sel_in = 40'h0000000000;
    endtask
    task automatic t_mem();
        {mem_mode_in, mem_wr_en_in} = 2'h3;
        mem_wr_addr_in = 4'hF;
        mem_wr_data_in = 20'hA5C3F;
        src_edge(0, 1'b1, 1);
        check(cell_q_out, exp_q);
        mem_wr_en_in = 1'b0;
        mem_rd_addr_in = 4'hF;
        src_edge(0, 1'b0, 0);
        check(mem_rd_data_out, 20'hA5C3F);
        mem_mode_in = 1'b0;
        tick();
        check(mem_rd_data_out, 20'h00000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge ref_clk_in);
        rst_in = 1'b0;
        tick();
        t_count();
        t_edges();
        t_gate();
        t_clears();
        t_chain();
        t_row();
        t_mem();
        stop_test();
    end
endmodule
